// File: src/og1_unit.sv
// operate group 1 microinstruction decoder and executor with wishbone registers
`timescale 1ns/1ps
`include "og1_cfg.svh"

// Notes on behaviour
// RULE1 - top three bits 111 mean operate class
// RULE2 - operate with bit 3 clear is group 1
// RULE3 - bit 3 set: bit 11 picks group 2/3
// RULE4 - combined bits: every selected action executes
// RULE5 - actions run in ascending sequence order
// RULE6 - same sequence actions happen together
// RULE7 - bits 4-7 zero/invert, bit 11 increments
// RULE8 - bits 8-10 select swap or rotates
// RULE9 - all-zero group 1 changes nothing, 10 states
// RULE10 - zero work register, 10 states
// RULE11 - zero carry flag, 10 states
// RULE12 - invert work register, 10 states
// RULE13 - invert carry flag, 10 states
// RULE14 - increment; carry out inverts carry flag
// RULE15 - swap six-bit halves, carry kept, 15 states
// RULE16 - rotate chain left one, 15 states
// RULE17 - rotate chain left two, 15 states
// RULE18 - rotate chain right one, 15 states
// RULE19 - rotate chain right two, 15 states
// RULE20 - each state lasts two clock periods
// RULE21 - bit 0 is msb; rotate means 15
// RULE22 - later steps use earlier step results
module og1_unit #(
  parameter int CLKS_PER_STATE = `OG1_CLKS_PER_ST
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire og1_pkg::og1_wb_req_t wb_req_i,
  output og1_pkg::og1_wb_rsp_t      wb_rsp_o,
  output logic [11:0]               work_o,
  output logic                      carry_o,
  output logic                      busy_o,
  output logic                      done_o
);
  import og1_pkg::*;

  // ----------------------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------------------
  og1_state_t  st;
  og1_state_t  next_st;
  logic        req;
  logic        wr;
  logic [31:0] lane_mask;
  logic [31:0] rd_data;
  logic [31:0] wr_word;
  logic [11:0] new_instr;
  logic [2:0]  rot;
  logic [12:0] inc_sum;

  // byte lane mask from wishbone select
  function automatic logic [31:0] sel_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = 32'h0000_0000;
    // each set select bit opens one byte lane
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        m[i*8 +: 8] = 8'hff;
      end
    end
    return m;
  endfunction

  // state count of a group 1 word: any rotate field code other than none costs the long form
  function automatic logic [4:0] g1_states(input logic [11:0] ins);
    // codes 110 and 111 move no data but still cost the long form
    if (ins[`OG1_ROT_HI:`OG1_ROT_LO] != `OG1_ROT_NONE)
    begin
      return `OG1_STATES_LONG;                        // [RULE21] [RULE15]
    end
    return `OG1_STATES_SHORT;                         // [RULE9] [RULE10] [RULE14]
  endfunction

  // clock periods for a number of states
  function automatic logic [4:0] clks_of(input logic [4:0] states);
    logic [9:0] prod;
    // wide product, cut to the counter width; defaults fit in five bits
    prod = 10'(states) * 10'(CLKS_PER_STATE);
    return prod[4:0];                                 // [RULE20]
  endfunction

  // ----------------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------------
  // a request is taken once; ack drops the cycle after it is given
  assign req       = wb_req_i.cyc && wb_req_i.stb && !st.rsp.ack;
  assign wr        = req && wb_req_i.we;
  assign lane_mask = sel_mask(wb_req_i.sel);
  assign rot       = st.instr[`OG1_ROT_HI:`OG1_ROT_LO];   // [RULE8]
  // increment with its carry out in bit 12
  assign inc_sum   = {1'b0, st.work} + 13'h0001;

  // register read mux; unmapped offsets read zero
  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (wb_req_i.adr)
      `OG1_ADR_INSTR:  rd_data[11:0] = st.instr;
      `OG1_ADR_WORK:   rd_data[11:0] = st.work;
      `OG1_ADR_CARRY:  rd_data[0]    = st.carry;
      `OG1_ADR_STATUS:
      begin
        // flags, group and state count
        rd_data[`OG1_ST_BUSY]            = st.busy;
        rd_data[`OG1_ST_DONE]            = st.done;
        rd_data[`OG1_ST_DROP]            = st.drop;
        rd_data[`OG1_ST_OPER]            = st.oper;
        rd_data[`OG1_ST_GRP_LO +: 2]     = st.grp;
        rd_data[`OG1_ST_STA_LO +: 5]     = st.states;
      end
      default:         rd_data = 32'h0000_0000;
    endcase
  end

  // merged write word for the addressed register, respecting byte lanes
  always_comb
  begin
    case (wb_req_i.adr)
      `OG1_ADR_INSTR:  wr_word = ({20'h00000, st.instr} & ~lane_mask) | (wb_req_i.dat & lane_mask);
      `OG1_ADR_WORK:   wr_word = ({20'h00000, st.work} & ~lane_mask) | (wb_req_i.dat & lane_mask);
      `OG1_ADR_CARRY:  wr_word = ({31'h0, st.carry} & ~lane_mask) | (wb_req_i.dat & lane_mask);
      default:         wr_word = wb_req_i.dat & lane_mask;
    endcase
  end

  // instruction bits of the merged write word
  assign new_instr = wr_word[11:0];

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  always_comb
  begin
    // hold everything; ack answers a taken request one clock later
    next_st            = st;
    next_st.done_pulse = 1'b0;
    next_st.rsp.ack    = req;
    next_st.rsp.dat    = req ? rd_data : st.rsp.dat;

    // sequencing of an accepted group 1 word, one logical step per clock
    case (st.fsm)
      OG1_IDLE:
      begin
        // waiting for a launched group 1 word
        next_st.fsm = OG1_IDLE;
      end
      OG1_SEQ1:
      begin
        // both clears act in the same step
        if (st.instr[`OG1_B_ZERO_WORK])
        begin
          next_st.work = 12'h000;                     // [RULE10] [RULE6]
        end
        if (st.instr[`OG1_B_ZERO_CARRY])
        begin
          next_st.carry = 1'b0;                       // [RULE11] [RULE6]
        end
        next_st.fsm = OG1_SEQ2;                       // [RULE5]
      end
      OG1_SEQ2:
      begin
        // both inversions act on the cleared values
        if (st.instr[`OG1_B_INV_WORK])
        begin
          next_st.work = ~st.work;                    // [RULE12] [RULE22]
        end
        if (st.instr[`OG1_B_INV_CARRY])
        begin
          next_st.carry = ~st.carry;                  // [RULE13] [RULE22]
        end
        next_st.fsm = OG1_SEQ3;                       // [RULE5]
      end
      OG1_SEQ3:
      begin
        // increment, carry out of the msb flips the carry flag
        if (st.instr[`OG1_B_INC])
        begin
          next_st.work = inc_sum[11:0];               // [RULE14] [RULE22]
          // carry out of the word msb
          if (inc_sum[12])
          begin
            next_st.carry = ~st.carry;                // [RULE14]
          end
        end
        next_st.fsm = OG1_SEQ4;                       // [RULE5]
      end
      OG1_SEQ4:
      begin
        // rotate chain is carry flag above the work register msb
        case (rot)
          `OG1_ROT_SWAP: next_st.work = {st.work[5:0], st.work[11:6]};   // [RULE15]
          `OG1_ROT_L1:
          begin
            next_st.carry = st.work[11];                                 // [RULE16]
            next_st.work  = {st.work[10:0], st.carry};                   // [RULE16]
          end
          `OG1_ROT_L2:
          begin
            next_st.carry = st.work[10];                                 // [RULE17]
            next_st.work  = {st.work[9:0], st.carry, st.work[11]};       // [RULE17]
          end
          `OG1_ROT_R1:
          begin
            next_st.carry = st.work[0];                                  // [RULE18]
            next_st.work  = {st.carry, st.work[11:1]};                   // [RULE18]
          end
          `OG1_ROT_R2:
          begin
            next_st.carry = st.work[1];                                  // [RULE19]
            next_st.work  = {st.work[0], st.carry, st.work[11:2]};       // [RULE19]
          end
          default: next_st.work = st.work;            // none, or unused codes
        endcase
        next_st.fsm = OG1_HOLD;                       // [RULE5]
      end
      OG1_HOLD:
      begin
        // steps finished; the counter closes the window
        next_st.fsm = OG1_HOLD;
      end
      default:
      begin
        // unused encodings fall back to idle
        next_st.fsm = OG1_IDLE;
      end
    endcase

    // busy window: exactly states times clocks per state
    if (st.fsm != OG1_IDLE)
    begin
      // last busy clock: release busy and pulse done
      if (st.cnt == 5'h01)
      begin
        next_st.fsm        = OG1_IDLE;                // [RULE20]
        next_st.busy       = 1'b0;
        next_st.done       = 1'b1;
        next_st.done_pulse = 1'b1;
      end
      else
      begin
        // otherwise one clock less to go
        next_st.cnt = st.cnt - 5'h01;                 // [RULE20]
      end
    end

    // register writes; a write of one to the status drop bit clears it
    if (wr)
    begin
      case (wb_req_i.adr)
        `OG1_ADR_INSTR:
        begin
          // a launch while executing is refused and flagged
          if (st.busy)
          begin
            next_st.drop = 1'b1;                      // refused while executing
          end
          else
          begin
            // accepted: fresh status before decoding
            next_st.instr  = new_instr;
            next_st.done   = 1'b0;
            next_st.oper   = (new_instr[`OG1_OPC_HI:`OG1_OPC_LO] == `OG1_OPCODE);  // [RULE1]
            next_st.states = 5'h00;
            next_st.grp    = OG1_GRP_NONE;
            // only operate class words get a group
            if (new_instr[`OG1_OPC_HI:`OG1_OPC_LO] == `OG1_OPCODE)
            begin
              if (!new_instr[`OG1_B_GROUP])
              begin
                // group 1 whatever bit 11 says; all action bits kept
                next_st.grp    = OG1_GRP_1;           // [RULE2] [RULE4] [RULE7]
                next_st.states = g1_states(new_instr);
                next_st.cnt    = clks_of(g1_states(new_instr));   // [RULE20]
                next_st.busy   = 1'b1;
                next_st.fsm    = OG1_SEQ1;
              end
              else if (new_instr[`OG1_B_LAST])
              begin
                // register pair group, recognised only
                next_st.grp = OG1_GRP_3;              // [RULE3]
              end
              else
              begin
                // test and skip group, recognised only
                next_st.grp = OG1_GRP_2;              // [RULE3]
              end
            end
          end
        end
        `OG1_ADR_WORK:
        begin
          // direct load, refused while executing
          if (st.busy)
          begin
            next_st.drop = 1'b1;
          end
          else
          begin
            next_st.work = wr_word[11:0];
          end
        end
        `OG1_ADR_CARRY:
        begin
          // direct load of the flag, refused while executing
          if (st.busy)
          begin
            next_st.drop = 1'b1;
          end
          else
          begin
            next_st.carry = wr_word[0];
          end
        end
        `OG1_ADR_STATUS:
        begin
          // clear drop only when byte lane 0 is selected and the drop bit is written as one
          if (wb_req_i.sel[0] && wb_req_i.dat[`OG1_ST_DROP])
          begin
            next_st.drop = 1'b0;
          end
        end
        default:
        begin
          next_st.drop = st.drop;                     // unmapped write ignored
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // every field to its reset value
      st.fsm        <= OG1_IDLE;
      st.grp        <= OG1_GRP_NONE;
      st.oper       <= 1'b0;
      st.instr      <= `OG1_RST_INSTR;
      st.work       <= `OG1_RST_WORK;
      st.carry      <= `OG1_RST_CARRY;
      st.states     <= 5'h00;
      st.cnt        <= 5'h00;
      st.busy       <= 1'b0;
      st.done       <= 1'b0;
      st.done_pulse <= 1'b0;
      st.drop       <= 1'b0;
      st.rsp        <= '0;
    end
    else
    begin
      // whole state advances together
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------------------
  assign wb_rsp_o = st.rsp;
  assign work_o   = st.work;
  assign carry_o  = st.carry;
  assign busy_o   = st.busy;
  assign done_o   = st.done_pulse;

endmodule // og1_unit

// File: src/og1_cfg.svh
// offsets, field positions, reset values and timing counts of the operate group 1 unit
`ifndef OG1_CFG_SVH
`define OG1_CFG_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define OG1_ADR_INSTR    8'h00
`define OG1_ADR_WORK     8'h04
`define OG1_ADR_CARRY    8'h08
`define OG1_ADR_STATUS   8'h0c

// ----------------------------------------------------------------------------
// instruction fields, as vector index (word bit 0 is vector bit 11)
// ----------------------------------------------------------------------------
`define OG1_OPC_HI       11
`define OG1_OPC_LO       9
`define OG1_OPCODE       3'h7
`define OG1_B_GROUP      8
`define OG1_B_LAST       0
`define OG1_B_ZERO_WORK  7
`define OG1_B_ZERO_CARRY 6
`define OG1_B_INV_WORK   5
`define OG1_B_INV_CARRY  4
`define OG1_ROT_HI       3
`define OG1_ROT_LO       1
`define OG1_B_INC        0

// rotate field codes
`define OG1_ROT_NONE     3'h0
`define OG1_ROT_SWAP     3'h1
`define OG1_ROT_L1       3'h2
`define OG1_ROT_L2       3'h3
`define OG1_ROT_R1       3'h4
`define OG1_ROT_R2       3'h5

// ----------------------------------------------------------------------------
// status fields, reset values, timing
// ----------------------------------------------------------------------------
`define OG1_ST_BUSY      0
`define OG1_ST_DONE      1
`define OG1_ST_DROP      2
`define OG1_ST_OPER      3
`define OG1_ST_GRP_LO    4
`define OG1_ST_STA_LO    8
`define OG1_RST_INSTR    12'h000
`define OG1_RST_WORK     12'h000
`define OG1_RST_CARRY    1'h0
`define OG1_STATES_SHORT 5'h0a
`define OG1_STATES_LONG  5'h0f
`define OG1_CLKS_PER_ST  2

`endif

// File: src/og1_pkg.sv
// types shared by the operate group 1 unit
package og1_pkg;

  // ----------------------------------------------------------------------------
  // wishbone carriers
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } og1_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } og1_wb_rsp_t;

  // ----------------------------------------------------------------------------
  // sequencing and decode
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {OG1_IDLE, OG1_SEQ1, OG1_SEQ2, OG1_SEQ3, OG1_SEQ4, OG1_HOLD} og1_fsm_t;
  typedef enum logic [1:0] {OG1_GRP_NONE, OG1_GRP_1, OG1_GRP_2, OG1_GRP_3} og1_grp_t;

  typedef struct packed {
    og1_fsm_t    fsm;
    og1_grp_t    grp;
    logic        oper;
    logic [11:0] instr;
    logic [11:0] work;
    logic        carry;
    logic [4:0]  states;
    logic [4:0]  cnt;
    logic        busy;
    logic        done;
    logic        done_pulse;
    logic        drop;
    og1_wb_rsp_t rsp;
  } og1_state_t;

endpackage

// File: dv/og1_unit_chk.sv
// port level assertion checker for the operate group 1 unit
`timescale 1ns/1ps
module og1_unit_chk #(
  parameter int CLKS_PER_STATE = 2
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire og1_pkg::og1_wb_req_t wb_req_i,
  input  wire og1_pkg::og1_wb_rsp_t wb_rsp_o,
  input  wire logic [11:0]          work_o,
  input  wire logic                 carry_o,
  input  wire logic                 busy_o,
  input  wire logic                 done_o
);
  import og1_pkg::*;

  logic [7:0] busy_cnt;

  // counts the busy cycles of one execution, holds the total one cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !busy_o)
      busy_cnt <= 8'h00;
    else
      busy_cnt <= busy_cnt + 8'h01;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  ack_timing_a: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack
    |=> wb_rsp_o.ack) else $error("ack missing one cycle after request");
  ack_pulse_a: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack longer than one cycle");

  // ----------------------------------------------------------------
  // execution timing and state
  // ----------------------------------------------------------------
  busy_start_a: assert property ($rose(busy_o) |-> wb_rsp_o.ack && wb_req_i.we)
    else $error("busy rose without an accepted write");
  busy_len_a: assert property ($fell(busy_o) |-> (busy_cnt == 8'(10 * CLKS_PER_STATE))
    || (busy_cnt == 8'(15 * CLKS_PER_STATE))) else $error("busy length wrong");
  done_after_a: assert property ($fell(busy_o) |-> done_o)
    else $error("done missing when busy fell");
  done_pulse_a: assert property (done_o |=> !done_o) else $error("done longer than one cycle");
  late_hold_a: assert property (busy_o && busy_cnt >= 8'd5 |-> $stable(work_o) && $stable(carry_o))
    else $error("work or carry moved after the last step");
  idle_hold_a: assert property (!busy_o ##1 !wb_rsp_o.ack |-> $stable(work_o) && $stable(carry_o))
    else $error("work or carry moved while idle");
endmodule // og1_unit_chk

// File: dv/og1_seq_model.sv
// wishbone master model of the fetch and execute sequencer
`timescale 1ns/1ps
module og1_seq_model (
  input  wire logic                 clk_i,
  output og1_pkg::og1_wb_req_t      wb_req_o,
  input  wire og1_pkg::og1_wb_rsp_t wb_rsp_i
);
  import og1_pkg::*;

  // bus idle at time zero
  initial
  begin
    wb_req_o = '0;
  end

  // one classic cycle after gap+1 idle cycles, held until ack is sampled
  task automatic cycle(input int gap, input logic we, input logic [7:0] adr,
                       input logic [31:0] wdat, output logic [31:0] rdat);
    repeat (gap + 1) @(posedge clk_i);
    wb_req_o <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: wdat};
    do
      @(posedge clk_i);
    while (wb_rsp_i.ack !== 1'b1);
    rdat = wb_rsp_i.dat;
    // released lines show the inverse of their last value
    wb_req_o <= '{cyc: 1'b0, stb: 1'b0, we: ~we, adr: ~adr, sel: 4'h0, dat: ~wdat};
  endtask
endmodule // og1_seq_model

// File: dv/testbench.sv
// self-checking testbench for the operate group 1 unit
`timescale 1ns/1ps
`include "og1_cfg.svh"
module testbench;
  import og1_pkg::*;
  localparam int CPS = 2;

  logic        clk_i;
  logic        rst_i;
  og1_wb_req_t wb_req;
  og1_wb_rsp_t wb_rsp;
  logic [11:0] work;
  logic        carry;
  logic        busy;
  logic        done;
  logic [31:0] rd;
  int          err_total;
  int          samples_checked;

  og1_unit #(.CLKS_PER_STATE(CPS)) og1_unit_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_req_i(wb_req), .wb_rsp_o(wb_rsp), .work_o(work), .carry_o(carry),
    .busy_o(busy), .done_o(done));
  og1_seq_model og1_seq_model_i (.clk_i(clk_i), .wb_req_o(wb_req), .wb_rsp_i(wb_rsp));

  // 250 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    og1_seq_model_i.cycle(0, 1'b1, a, d, rd);
  endtask

  task automatic rdr(input logic [7:0] a);
    og1_seq_model_i.cycle(1, 1'b0, a, 32'h0, rd);
  endtask

  // loads state, launches a word, times it and compares the result
  task automatic run(input logic [11:0] ins, input logic [11:0] w0, input logic c0,
                     input logic [11:0] w1, input logic c1, input int n);
    int k;
    wr(`OG1_ADR_WORK, {20'h0, w0});
    wr(`OG1_ADR_CARRY, {31'h0, c0});
    wr(`OG1_ADR_INSTR, {20'h0, ins});
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (busy === 1'b1 && k < 100);
    check("cycles", k, n * CPS);
    check("done", {31'h0, done}, 32'h1);
    check("work", {20'h0, work}, {20'h0, w1});
    check("carry", {31'h0, carry}, {31'h0, c1});
    rdr(`OG1_ADR_STATUS);
    check("status", rd & 32'h1f3f, (32'(n) << 8) | 32'h1a);
  endtask

  task automatic one(input logic [11:0] ins, input logic [11:0] w1, input logic c1, input int n);
    run(ins, 12'ha53, 1'b1, w1, c1, n);
  endtask

  // reset values seen on the ports and in the registers
  task automatic t_reset();
    check("work", {20'h0, work}, {20'h0, `OG1_RST_WORK});
    check("carry", {31'h0, carry}, {31'h0, `OG1_RST_CARRY});
    check("flags", {30'h0, busy, done}, 32'h0);
    rdr(`OG1_ADR_STATUS);
    check("status", rd, 32'h0);
    rdr(`OG1_ADR_INSTR);
    check("instr", rd, {20'h0, `OG1_RST_INSTR});
    $display("test reset values done");
  endtask

  // every single group 1 action
  task automatic t_single();
    one(12'he00, 12'ha53, 1'b1, 10);
    one(12'he80, 12'h000, 1'b1, 10);
    one(12'he40, 12'ha53, 1'b0, 10);
    one(12'he20, 12'h5ac, 1'b1, 10);
    one(12'he10, 12'ha53, 1'b0, 10);
    one(12'he01, 12'ha54, 1'b1, 10);
    run(12'he01, 12'hfff, 1'b1, 12'h000, 1'b0, 10);
    one(12'he02, 12'h4e9, 1'b1, 15);
    one(12'he04, 12'h4a7, 1'b1, 15);
    one(12'he06, 12'h94f, 1'b0, 15);
    one(12'he08, 12'hd29, 1'b1, 15);
    one(12'he0a, 12'he94, 1'b1, 15);
    $display("test single actions done");
  endtask

  // combined words in sequence order, then the two unused rotate codes alone
  task automatic t_combo();
    one(12'he81, 12'h001, 1'b1, 10);
    one(12'hea0, 12'hfff, 1'b1, 10);
    one(12'hec0, 12'h000, 1'b0, 10);
    one(12'he30, 12'h5ac, 1'b0, 10);
    one(12'he21, 12'h5ad, 1'b1, 10);
    one(12'hed5, 12'h003, 1'b0, 15);
    one(12'heda, 12'h400, 1'b0, 15);
    one(12'hee8, 12'h7ff, 1'b1, 15);
    one(12'he0c, 12'ha53, 1'b1, 15);
    one(12'he0e, 12'ha53, 1'b1, 15);
    $display("test combined words done");
  endtask

  // words outside group 1, a write while busy, an unmapped read
  task automatic t_other();
    logic [11:0] word [3] = '{12'h29c, 12'hf08, 12'hf09};
    logic [31:0] grp [3] = '{32'h00, 32'h28, 32'h38};
    wr(`OG1_ADR_WORK, 32'h0a53);
    foreach (word[i])
    begin
      wr(`OG1_ADR_INSTR, {20'h0, word[i]});
      repeat (4) @(posedge clk_i);
      check("busy", {31'h0, busy}, 32'h0);
      rdr(`OG1_ADR_STATUS);
      check("group", rd & 32'h1f3b, grp[i]);
    end
    check("work", {20'h0, work}, 32'h0a53);
    wr(`OG1_ADR_INSTR, 32'h0e80);
    wr(`OG1_ADR_WORK, 32'h0123);
    repeat (24) @(posedge clk_i);
    check("work", {20'h0, work}, 32'h0);
    rdr(`OG1_ADR_STATUS);
    check("drop", rd & 32'h4, 32'h4);
    wr(`OG1_ADR_STATUS, 32'h4);
    rdr(`OG1_ADR_STATUS);
    check("drop clear", rd & 32'h6, 32'h2);
    rdr(8'h10);
    check("unmapped", rd, 32'h0);
    $display("test other words done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // main sequence
  initial
  begin
    err_total = 0;
    samples_checked = 0;
    rst_i = 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_single();
    t_combo();
    t_other();
    end_of_test();
  end

  // watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    end_of_test();
  end
endmodule // testbench

bind og1_unit og1_unit_chk #(.CLKS_PER_STATE(CLKS_PER_STATE)) og1_unit_chk_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
  .work_o(work_o), .carry_o(carry_o), .busy_o(busy_o), .done_o(done_o));
